// *** bwe_pkg.sv ***
// Purpose: shared constants and types for the byte write strobe decoder
// Assumes: 32-bit data bus, four shared pins
// Notes: pin_function_select uses two bits per pin
package bwe_pkg;
  localparam int NUM_PINS = 4;
  // per-pin function codes
  typedef enum logic [1:0] {
    BWE_FN_STROBE = 2'h0,
    BWE_FN_ADDR = 2'h1,
    BWE_FN_CS = 2'h2,
    BWE_FN_RSVD = 2'h3
  } bwe_fn_t;
  // transfer size codes
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LINE = 2'h3;
  // port width codes
  typedef enum logic [1:0] {
    BWE_PW_32 = 2'h0,
    BWE_PW_8 = 2'h1,
    BWE_PW_16 = 2'h2
  } bwe_pw_t;
  localparam logic [7:0] PFS_RESET = 8'h00;
  localparam logic [3:0] STROBE_IDLE = 4'hf;
endpackage

// *** bwe_dec_if.sv ***
`timescale 1ns/10ps
// Purpose: carries one transfer's attributes to the strobe decoder
// Assumes: single clock domain
// Notes: strobes come back active low
interface bwe_dec_if;
  logic [1:0] size;
  logic [1:0] addr_lo;
  logic [1:0] port_width;
  logic burst;
  logic [3:0] strobe_n;
  modport req (output size, output addr_lo, output port_width, output burst, input strobe_n);
  modport dec (input size, input addr_lo, input port_width, input burst, output strobe_n);
endinterface

// *** bwe_lane_dec.sv ***
`timescale 1ns/10ps
// Purpose: combinational lane decode from size, address, width
// Assumes: caller gates with write qualification
// Notes: burst does not alter lanes per table; kept as an input
module bwe_lane_dec (
  bwe_dec_if.dec d
);
  import bwe_pkg::*;
  // lane index 0 is the most significant byte
  function automatic logic [3:0] lane_bit(input logic [1:0] idx);
    lane_bit = 4'h1 << idx;
  endfunction
  logic [3:0] act;
  always_comb begin
    act = 4'h0;
    unique case (d.port_width)
      BWE_PW_8: act = 4'h1;
      BWE_PW_16: begin
        if (d.size == SZ_BYTE) act = lane_bit({1'b0, d.addr_lo[0]});
        else act = 4'h3;
      end
      default: begin
        unique case (d.size)
          SZ_BYTE: act = lane_bit(d.addr_lo);
          SZ_WORD: act = d.addr_lo[1] ? 4'hc : 4'h3;
          default: act = 4'hf;
        endcase
      end
    endcase
  end
  // bit i of act drives strobe i, active low
  assign d.strobe_n = ~act;
endmodule // bwe_lane_dec

// *** bwe_top.sv ***
`timescale 1ns/10ps
// Purpose: drives four shared pins as address bits, chip selects or byte write strobes
// Assumes: transfer qualifiers arrive on clk; irq pins are asynchronous
// Notes: strobe i gates data lane 31-8i..24-8i
module bwe_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] pin_function_select,
  input wire logic xfer_valid,
  input wire logic xfer_write,
  input wire logic [bwe_pkg::NUM_PINS-1:0] transfer_size_code,
  input wire logic [1:0] addr_lo,
  input wire logic [3:0] addr_hi,
  input wire logic [3:0] cs_hi_n,
  input wire logic [1:0] region_port_width,
  input wire logic region_burst,
  input wire logic use_boot_region,
  input wire logic [2:0] encoded_irq_level_n,
  output logic [3:0] shared_pin,
  output logic [1:0] boot_port_width,
  output logic boot_auto_ack
);
  import bwe_pkg::*;

  // ==========================================
  // boot strap capture
  logic [2:0] irq_s1_q;
  logic [2:0] irq_s2_q;
  logic in_rst_q;
  // no reset on the synchroniser: it must keep sampling the pins while reset is held
  always_ff @(posedge clk) begin
    irq_s1_q <= encoded_irq_level_n;
    irq_s2_q <= irq_s1_q;
  end
  // capture takes the second edge after release, from the synchroniser output
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) in_rst_q <= 1'b1;
    else in_rst_q <= 1'b0;
  end
  logic [1:0] boot_pw_q;
  logic boot_aa_q;
  logic strap_done_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_pw_q <= BWE_PW_32;
      boot_aa_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q && !in_rst_q) begin
      strap_done_q <= 1'b1;
      boot_aa_q <= irq_s2_q[2];
      unique case (irq_s2_q[1:0])
        2'h0: boot_pw_q <= BWE_PW_32;
        2'h1: boot_pw_q <= BWE_PW_8;
        default: boot_pw_q <= BWE_PW_16;
      endcase
    end
  end
  assign boot_port_width = boot_pw_q;
  assign boot_auto_ack = boot_aa_q;

  // ==========================================
  // pin function select
  logic [7:0] pfs_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) pfs_q <= PFS_RESET;
    else pfs_q <= pin_function_select;
  end

  // ==========================================
  // strobe decode
  bwe_dec_if dif();
  assign dif.size = transfer_size_code[1:0];
  assign dif.addr_lo = addr_lo;
  assign dif.port_width = use_boot_region ? boot_pw_q : region_port_width;
  assign dif.burst = region_burst;
  bwe_lane_dec u_dec (
    .d(dif.dec)
  );

  logic wr_act;
  assign wr_act = xfer_valid && xfer_write && strap_done_q;
  logic [3:0] pin_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_q <= STROBE_IDLE;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        unique case (bwe_fn_t'(pfs_q[2*i +: 2]))
          BWE_FN_ADDR: pin_q[i] <= addr_hi[i];
          BWE_FN_CS: pin_q[i] <= cs_hi_n[i];
          BWE_FN_STROBE: pin_q[i] <= wr_act ? dif.strobe_n[i] : 1'b1;
          default: pin_q[i] <= 1'b1;
        endcase
      end
    end
  end
  assign shared_pin = pin_q;

  // ==========================================
  // checks
  // the size code's upper bits carry nothing; only the low pair is decoded
  logic [1:0] size_lo;
  assign size_lo = transfer_size_code[1:0];
  // a write the strobe decode may act on, with every pin in strobe mode
  sequence s_lane_write;
    pfs_q == PFS_RESET && wr_act;
  endsequence
  // the edge just after release, then the edge that takes the strap
  sequence s_strap_capture;
    in_rst_q ##1 (!in_rst_q && !strap_done_q);
  endsequence

  a_reset_strobe_fn: assert property (@(posedge clk) disable iff (sys_rst)
    in_rst_q
    |-> pfs_q == PFS_RESET && pin_q == STROBE_IDLE)
    else $error("pin function not strobe after reset");
  a_strobe_read_idle: assert property (@(posedge clk) disable iff (sys_rst)
    pfs_q == PFS_RESET && !(xfer_valid && xfer_write)
    |=> pin_q == STROBE_IDLE)
    else $error("strobe asserted outside write");
  a_strobe_before_strap: assert property (@(posedge clk) disable iff (sys_rst)
    pfs_q == PFS_RESET && !strap_done_q
    |=> pin_q == STROBE_IDLE)
    else $error("strobe asserted before strap capture");

  // lane pattern per port width; strobe i is pin bit i, low when active
  a_byte8_lane0: assert property (@(posedge clk) disable iff (sys_rst)
    s_lane_write ##0 (dif.port_width == BWE_PW_8)
    |=> pin_q == 4'he)
    else $error("8-bit port not on strobe 0");
  a_byte16_sel: assert property (@(posedge clk) disable iff (sys_rst)
    s_lane_write ##0 (dif.port_width == BWE_PW_16 && size_lo == SZ_BYTE)
    |=> pin_q == ($past(addr_lo[0]) ? 4'hd : 4'he))
    else $error("16-bit byte strobe wrong");
  a_word16_pair: assert property (@(posedge clk) disable iff (sys_rst)
    s_lane_write ##0 (dif.port_width == BWE_PW_16 && size_lo == SZ_WORD)
    |=> pin_q == 4'hc)
    else $error("16-bit word strobes wrong");
  a_long16_pair: assert property (@(posedge clk) disable iff (sys_rst)
    s_lane_write ##0 (dif.port_width == BWE_PW_16
      && (size_lo == SZ_LONG || size_lo == SZ_LINE))
    |=> pin_q == 4'hc)
    else $error("16-bit long strobes wrong");
  a_byte32_lane: assert property (@(posedge clk) disable iff (sys_rst)
    s_lane_write ##0 (dif.port_width == BWE_PW_32 && size_lo == SZ_BYTE)
    |=> pin_q == ($past(addr_lo) == 2'h0 ? 4'he : $past(addr_lo) == 2'h1 ? 4'hd :
      $past(addr_lo) == 2'h2 ? 4'hb : 4'h7))
    else $error("32-bit byte strobe wrong");
  a_word32_pair: assert property (@(posedge clk) disable iff (sys_rst)
    s_lane_write ##0 (dif.port_width == BWE_PW_32 && size_lo == SZ_WORD)
    |=> pin_q == ($past(addr_lo[1]) ? 4'h3 : 4'hc))
    else $error("word strobe pair wrong");
  a_long32_all: assert property (@(posedge clk) disable iff (sys_rst)
    s_lane_write ##0 (dif.port_width == BWE_PW_32 && size_lo == SZ_LONG)
    |=> pin_q == 4'h0)
    else $error("longword strobes wrong");
  a_line32_all: assert property (@(posedge clk) disable iff (sys_rst)
    s_lane_write ##0 (dif.port_width == BWE_PW_32 && size_lo == SZ_LINE)
    |=> pin_q == 4'h0)
    else $error("line strobes wrong");
  a_boot_region_sel: assert property (@(posedge clk) disable iff (sys_rst)
    s_lane_write ##0 (use_boot_region && boot_pw_q == BWE_PW_8)
    |=> pin_q == 4'he)
    else $error("boot region width not used");
  a_region_sel: assert property (@(posedge clk) disable iff (sys_rst)
    s_lane_write ##0 (!use_boot_region && region_port_width == BWE_PW_8)
    |=> pin_q == 4'he)
    else $error("region width not used");

  // mixed pin functions, one pin per function
  a_strobe_mixed: assert property (@(posedge clk) disable iff (sys_rst)
    pfs_q[1:0] == BWE_FN_STROBE && wr_act && dif.port_width == BWE_PW_32
    && size_lo == SZ_LONG |=> !pin_q[0])
    else $error("strobe pin silent in mixed mode");
  a_strobe_rest_high: assert property (@(posedge clk) disable iff (sys_rst)
    pfs_q[1:0] == BWE_FN_STROBE && !wr_act
    |=> pin_q[0])
    else $error("strobe pin low without write");
  a_addr_pass: assert property (@(posedge clk) disable iff (sys_rst)
    pfs_q[3:2] == BWE_FN_ADDR
    |=> pin_q[1] == $past(addr_hi[1]))
    else $error("address mode not passed");
  a_cs_pass: assert property (@(posedge clk) disable iff (sys_rst)
    pfs_q[5:4] == BWE_FN_CS
    |=> pin_q[2] == $past(cs_hi_n[2]))
    else $error("chip select mode not passed");
  a_spare_high: assert property (@(posedge clk) disable iff (sys_rst)
    pfs_q[7:6] == BWE_FN_RSVD
    |=> pin_q[3])
    else $error("unused pin code not held high");

  // boot strap: one capture, shortly after release, then held
  a_boot_w32: assert property (@(posedge clk) disable iff (sys_rst)
    s_strap_capture ##0 (irq_s2_q[1:0] == 2'h0)
    |=> boot_pw_q == BWE_PW_32)
    else $error("boot width strap not 32-bit");
  a_boot_w8: assert property (@(posedge clk) disable iff (sys_rst)
    s_strap_capture ##0 (irq_s2_q[1:0] == 2'h1)
    |=> boot_pw_q == BWE_PW_8)
    else $error("boot width strap not 8-bit");
  a_boot_w16: assert property (@(posedge clk) disable iff (sys_rst)
    s_strap_capture ##0 (irq_s2_q[1])
    |=> boot_pw_q == BWE_PW_16)
    else $error("boot width strap not 16-bit");
  a_boot_aa: assert property (@(posedge clk) disable iff (sys_rst)
    s_strap_capture
    |=> boot_aa_q == $past(irq_s2_q[2]))
    else $error("boot auto ack strap wrong");
  a_strap_default: assert property (@(posedge clk) disable iff (sys_rst)
    !strap_done_q
    |-> boot_pw_q == BWE_PW_32 && !boot_aa_q)
    else $error("boot defaults wrong before capture");
  a_strap_once: assert property (@(posedge clk) disable iff (sys_rst)
    strap_done_q
    |=> strap_done_q && $stable(boot_pw_q) && $stable(boot_aa_q))
    else $error("boot strap changed after capture");
endmodule // bwe_top

// *** bwe_mem_model.sv ***
// Purpose: far-side memory that turns write strobes into data lane enables
// Assumes: strobes active low, strobe 0 on the top byte
// Notes: lane_we[k] enables data bits 8k+7..8k
`timescale 1ns/10ps
module bwe_mem_model (
  input wire logic [3:0] strobe_n,
  output logic [3:0] lane_we
);
  // the memory only ever sees the pins; a low strobe writes its lane
  assign lane_we = {~strobe_n[0], ~strobe_n[1], ~strobe_n[2], ~strobe_n[3]};
endmodule // bwe_mem_model

// *** tb_bwe_top.sv ***
// Purpose: self-checking bench for the byte write strobe decoder
// Assumes: 125 MHz clock, async active-high reset
// Notes: strobe patterns worked out from size, address and port width
`timescale 1ns/10ps
module tb_bwe_top;
  import bwe_pkg::*;
  logic clk = 0, sys_rst = 1, xfer_valid = 0, xfer_write = 0, region_burst = 0;
  logic use_boot_region = 0;
  logic [7:0] pin_function_select = 8'h00;
  logic [3:0] transfer_size_code = 4'h0, addr_hi = 4'h0, cs_hi_n = 4'hf, shared_pin, lane_we;
  logic [1:0] addr_lo = 2'h0, region_port_width = 2'h0, boot_port_width;
  logic [2:0] encoded_irq_level_n = 3'h7;
  logic boot_auto_ack;
  int n_errors = 0, compares = 0;
  bwe_top i_bwe_top (.clk(clk), .sys_rst(sys_rst), .pin_function_select(pin_function_select),
    .xfer_valid(xfer_valid), .xfer_write(xfer_write), .transfer_size_code(transfer_size_code),
    .addr_lo(addr_lo), .addr_hi(addr_hi), .cs_hi_n(cs_hi_n), .region_burst(region_burst),
    .region_port_width(region_port_width), .use_boot_region(use_boot_region),
    .encoded_irq_level_n(encoded_irq_level_n), .shared_pin(shared_pin),
    .boot_port_width(boot_port_width), .boot_auto_ack(boot_auto_ack));
  bwe_mem_model i_bwe_mem_model (.strobe_n(shared_pin), .lane_we(lane_we));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [3:0] exp_st(input logic [1:0] sz, input logic [1:0] a,
                                         input logic [1:0] pw);
    case (pw)
      2'h1: return 4'he;
      2'h2: return (sz == SZ_BYTE) ? (a[0] ? 4'hd : 4'he) : 4'hc;
      default: return (sz == SZ_BYTE) ? ~(4'h1 << a) : (sz == SZ_WORD) ? (a[1] ? 4'h3 : 4'hc) : 4'h0;
    endcase
  endfunction
  // rest level of each pin from its function: address, chip select, or high
  function automatic logic [3:0] exp_idle(input logic [7:0] sel, input logic [3:0] ah,
                                          input logic [3:0] cs);
    logic [3:0] r;
    for (int i = 0; i < 4; i++) begin
      case (sel[2*i +: 2])
        2'h1: r[i] = ah[i];
        2'h2: r[i] = cs[i];
        default: r[i] = 1'b1;
      endcase
    end
    return r;
  endfunction
  // strap pins held steady across the whole reset and well after release
  task automatic do_reset(input logic [2:0] irq);
    @(posedge clk);
    encoded_irq_level_n <= irq;
    sys_rst <= 1'b1;
    pin_function_select <= PFS_RESET;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check({2'h0, boot_port_width}, (irq[1:0] == 2'h0) ? 4'h0 : (irq[1:0] == 2'h1) ? 4'h1 : 4'h2);
    check({3'h0, boot_auto_ack}, {3'h0, irq[2]});
    check(shared_pin, STROBE_IDLE);
  endtask
  task automatic xfer(input logic wr, input logic [1:0] sz, input logic [1:0] a,
                      input logic [1:0] pw, input logic bst, input logic [3:0] exp);
    @(posedge clk);
    xfer_valid <= 1'b1;
    xfer_write <= wr;
    transfer_size_code <= {2'h0, sz};
    addr_lo <= a;
    region_port_width <= pw;
    region_burst <= bst;
    @(posedge clk);
    xfer_valid <= 1'b0;
    #1;
    check(shared_pin, exp);
    check(lane_we, {~exp[0], ~exp[1], ~exp[2], ~exp[3]});
    @(posedge clk);
    #1;
    check(shared_pin, exp_idle(pin_function_select, addr_hi, cs_hi_n));
  endtask
  task automatic lane_table();
    for (int pw = 0; pw < 3; pw++)
      for (int k = 0; k < 32; k++)
        xfer(1'b1, k[1:0], k[3:2], pw[1:0], k[4], exp_st(k[1:0], k[3:2], pw[1:0]));
    xfer(1'b0, SZ_LONG, 2'h0, 2'h0, 1'b0, 4'hf);
  endtask
  task automatic pin_modes();
    @(posedge clk);
    pin_function_select <= 8'he4;
    addr_hi <= 4'h4;
    cs_hi_n <= 4'hb;
    repeat (2) @(posedge clk);
    #1;
    check(shared_pin, 4'h9);
    xfer(1'b1, SZ_LONG, 2'h0, 2'h0, 1'b0, 4'h8);
  endtask
  task automatic boot_width();
    @(posedge clk);
    use_boot_region <= 1'b1;
    xfer(1'b1, SZ_BYTE, 2'h3, 2'h0, 1'b0, exp_st(SZ_BYTE, 2'h3, 2'h1));
    use_boot_region <= 1'b0;
  endtask
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
  initial begin
    do_reset(3'h0);
    xfer(1'b1, SZ_BYTE, 2'h2, 2'h0, 1'b0, 4'hb);
    lane_table();
    pin_modes();
    do_reset(3'h6);
    xfer(1'b1, SZ_WORD, 2'h0, 2'h0, 1'b0, 4'hc);
    do_reset(3'h7);
    do_reset(3'h1);
    boot_width();
    close_out();
  end
endmodule // tb_bwe_top
